// ===== src/fast_gate_map.vh
// Register map and timing constants of the fast gate and alternate reset block.
`ifndef FAST_GATE_MAP_VH
`define FAST_GATE_MAP_VH

// Word offsets on the register bus (byte addresses).
`define FG_ADDR_FAST_GATE 8'h00
`define FG_ADDR_CONFIG 8'h04

// Fast gate register fields.
`define FG_BIT_RESET_REQ 0
`define FG_BIT_ALT_GATE 1
`define FG_FIXED_READ 8'h24
`define FG_FIXED_MASK 8'hFC

// Reset/gate configuration register fields.
`define FG_CFG_ENABLE_BIT 2
`define FG_CFG_POL_BIT 3
`define FG_CFG_RESET 8'h00

// Pulse timing: times in ns, clock period in ns.
`define FG_CLK_PERIOD_NS 100
`define FG_DELAY_NS 14000
`define FG_WIDTH_NS 6000
`define FG_DELAY_CYCLES ((`FG_DELAY_NS + `FG_CLK_PERIOD_NS - 1) / `FG_CLK_PERIOD_NS)
`define FG_WIDTH_CYCLES ((`FG_WIDTH_NS + `FG_CLK_PERIOD_NS - 1) / `FG_CLK_PERIOD_NS)

`endif

// ===== src/fast_reset_pulser.v
// Delayed low pulse generator driven by the fast reset request bit.
`default_nettype none

module fast_reset_pulser #(
    parameter DELAY_CYCLES = 140,
    parameter WIDTH_CYCLES = 60,
    parameter CNT_W = 16
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_reset_n,
    // Request level from the register bit.
    input wire i_request,
    // Pulse output, active low.
    output reg o_pulse_n
);

    localparam ST_IDLE = 2'd0;
    localparam ST_DELAY = 2'd1;
    localparam ST_PULSE = 2'd2;
    localparam ST_DONE = 2'd3;
    // Last counts are worked out at full width, then cut to the counter on purpose.
    localparam [31:0] DELAY_M1 = DELAY_CYCLES - 1;
    localparam [31:0] WIDTH_M1 = WIDTH_CYCLES - 1;
    localparam [CNT_W-1:0] DELAY_LAST = DELAY_M1[CNT_W-1:0];
    localparam [CNT_W-1:0] WIDTH_LAST = WIDTH_M1[CNT_W-1:0];

    reg [1:0] state;
    reg [CNT_W-1:0] count;

    ////////////////////////////////////////////////////////////////////////////////
    // One pulse per request; a new pulse needs the request to drop first.
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            count <= {CNT_W{1'b0}};
            o_pulse_n <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    o_pulse_n <= 1'b1;
                    count <= {CNT_W{1'b0}};
                    if (i_request) begin
                        state <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (count == DELAY_LAST) begin
                        count <= {CNT_W{1'b0}};
                        o_pulse_n <= 1'b0;
                        state <= ST_PULSE;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_PULSE: begin
                    if (count == WIDTH_LAST) begin
                        o_pulse_n <= 1'b1;
                        state <= ST_DONE;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_DONE: begin
                    o_pulse_n <= 1'b1;
                    // Re-arm only once the bit is back at zero.
                    if (!i_request) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    o_pulse_n <= 1'b1;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== src/fast_gate_and_alt_reset.v
// Fast address gate and alternate CPU reset register block with a Wishbone slave.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`include "fast_gate_map.vh"
`default_nettype none

module fast_gate_and_alt_reset #(
    parameter DELAY_CYCLES = `FG_DELAY_CYCLES,
    parameter WIDTH_CYCLES = `FG_WIDTH_CYCLES
) (
    // Clock and synchronous reset.
    input wire i_clk,
    input wire i_reset_n,
    // Classic Wishbone slave.
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    // Keyboard controller signals, asynchronous to this clock.
    input wire i_kbc_gate_port_bit,
    input wire i_kbc_reset_out_n,
    // Outputs toward the CPU and board.
    output reg o_alt_gate_line,
    output reg o_gate_output_n,
    output reg o_fast_reset_out_n,
    output reg o_shared_kbd_reset_pin
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state and bus decode.

    reg [7:0] reset_gate_config_reg;
    reg reset_req_bit;
    wire fast_pulse_n;
    wire bus_req;
    wire port_enabled;
    reg [7:0] next_read;

    // Decodes a byte address to a register hit.
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // A request is taken only once; ack drops the cycle after it was given.
    assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign port_enabled = reset_gate_config_reg[`FG_CFG_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Asynchronous inputs pass three flops; a change counts when the last two agree.

    reg [2:0] gate_sync;
    reg [2:0] krst_sync;
    reg gate_level;
    reg krst_level;

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            gate_sync <= 3'h0;
            krst_sync <= 3'h7;
            gate_level <= 1'b0;
            krst_level <= 1'b1;
        end else begin
            gate_sync <= {gate_sync[1:0], i_kbc_gate_port_bit};
            krst_sync <= {krst_sync[1:0], i_kbc_reset_out_n};
            if (gate_sync[1] == gate_sync[2]) begin
                gate_level <= gate_sync[2];
            end
            if (krst_sync[1] == krst_sync[2]) begin
                krst_level <= krst_sync[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes. Fast gate writes are dropped while the port is disabled.

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            reset_gate_config_reg <= `FG_CFG_RESET;
            reset_req_bit <= 1'b0;
            o_alt_gate_line <= 1'b0;
        end else if (bus_req && i_wb_we && i_wb_sel[0]) begin
            if (addr_hit(i_wb_adr, `FG_ADDR_CONFIG)) begin
                reset_gate_config_reg <= i_wb_dat[7:0];
            end else if (addr_hit(i_wb_adr, `FG_ADDR_FAST_GATE) && port_enabled) begin
                reset_req_bit <= i_wb_dat[`FG_BIT_RESET_REQ];
                o_alt_gate_line <= i_wb_dat[`FG_BIT_ALT_GATE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux. Unmapped or disabled reads return zero but are still acknowledged.

    always @* begin
        next_read = 8'h00;
        if (addr_hit(i_wb_adr, `FG_ADDR_CONFIG)) begin
            next_read = reset_gate_config_reg;
        end else if (addr_hit(i_wb_adr, `FG_ADDR_FAST_GATE) && port_enabled) begin
            // Fixed pattern gives 00 in 7:6, 1 in 5 and 2, 0 in 4 and 3.
            next_read = `FG_FIXED_READ;
            next_read[`FG_BIT_ALT_GATE] = o_alt_gate_line;
            next_read[`FG_BIT_RESET_REQ] = reset_req_bit;
        end
    end

    // Ack one cycle after the request is seen; data is registered with it.
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= bus_req;
            if (bus_req && !i_wb_we) begin
                o_wb_dat <= {24'h000000, next_read};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse timing lives in its own counter so the bus stays independent of it.

    fast_reset_pulser #(
        .DELAY_CYCLES(DELAY_CYCLES),
        .WIDTH_CYCLES(WIDTH_CYCLES),
        .CNT_W(16)
    ) u_pulser (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_request(reset_req_bit),
        .o_pulse_n(fast_pulse_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output combining, registered so every output comes from a flop.

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_gate_output_n <= 1'b0;
            o_fast_reset_out_n <= 1'b1;
            o_shared_kbd_reset_pin <= 1'b1;
        end else begin
            // Gate output is low only when both sources are low.
            o_gate_output_n <= gate_level | o_alt_gate_line;
            o_fast_reset_out_n <= fast_pulse_n;
            // The fast pulse joins the controller reset only when the port is enabled.
            o_shared_kbd_reset_pin <= (krst_level & (fast_pulse_n | ~port_enabled))
                ^ reset_gate_config_reg[`FG_CFG_POL_BIT];
        end
    end

endmodule

`default_nettype wire

// ===== bench/kbc_side_model.sv
// Keyboard controller side model that drives the gate port bit and the controller reset line.
`default_nettype none
module kbc_side_model (
    // Clock and bench requests.
    input wire logic i_clk,
    input wire logic i_gate,
    input wire logic i_reset_req,
    // Lines toward the block.
    output logic o_kbc_gate_port_bit,
    output logic o_kbc_reset_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins move on the same i_clk edge as the block, which still passes them through its synchronisers.
    // The bench holds both requests idle from time zero, so the lines settle during reset.
    always @(posedge i_clk) begin
        o_kbc_gate_port_bit <= i_gate;
        o_kbc_reset_out_n <= !i_reset_req;
    end
endmodule
`default_nettype wire

// ===== bench/fast_gate_and_alt_reset_asserts.sv
// Concurrent checks of the fast gate block at its ports.
`default_nettype none
module fast_gate_checker #(
    parameter int DELAY_CYCLES = 140,
    parameter int WIDTH_CYCLES = 60
) (
    // Clock, reset and bus.
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // Gate and reset lines.
    input wire logic i_kbc_gate_port_bit,
    input wire logic o_alt_gate_line,
    input wire logic o_gate_output_n,
    input wire logic o_fast_reset_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic en, alt, b0, arm;
    logic [7:0] since, low;
    wire logic wr = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0];
    wire logic wr0 = wr && i_wb_adr == 8'h00 && en;
    // Shadow of software writes; counters bound the long pulse waits.
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            en <= 1'h0;
            alt <= 1'h0;
            b0 <= 1'h0;
            arm <= 1'h0;
            since <= 8'h00;
        end else begin
            if (wr && i_wb_adr == 8'h04) en <= i_wb_dat[2];
            if (wr0) alt <= i_wb_dat[1];
            if (wr0) b0 <= i_wb_dat[0];
            if (wr0 && i_wb_dat[0] && !b0) begin
                arm <= 1'h1;
                since <= 8'h00;
            end else begin
                if ($fell(o_fast_reset_out_n)) arm <= 1'h0;
                if (since != 8'hFF) since <= since + 8'h01;
            end
        end
        low <= o_fast_reset_out_n ? 8'h00 : low + 8'h01;
    end
    sequence rd_fast;
        o_wb_ack && !i_wb_we && i_wb_adr == 8'h00;
    endsequence
    top_zero_a: assert property (rd_fast |-> o_wb_dat[7:6] == 2'h0) else $error("top bits set");
    fixed_bits_a: assert property (rd_fast ##0 en |-> o_wb_dat[5:0] == {4'h9, alt, b0})
        else $error("bad read value");
    closed_port_a: assert property (rd_fast ##0 !en |-> o_wb_dat == 32'h0) else $error("port open");
    alt_line_a: assert property ($stable(alt) [*3] |-> o_alt_gate_line == alt) else $error("alt line");
    gate_or_a: assert property (($stable(i_kbc_gate_port_bit) && $stable(o_alt_gate_line)) [*8]
        |-> o_gate_output_n == (i_kbc_gate_port_bit || o_alt_gate_line)) else $error("gate output");
    pulse_width_a: assert property ($rose(o_fast_reset_out_n) |-> low == WIDTH_CYCLES) else $error("width");
    pulse_start_a: assert property ($fell(o_fast_reset_out_n) |-> arm && since >= DELAY_CYCLES)
        else $error("early or extra pulse");
    pulse_due_a: assert property (!(arm && since > DELAY_CYCLES + 6)) else $error("pulse late");
endmodule
bind fast_gate_and_alt_reset fast_gate_checker #(.DELAY_CYCLES(DELAY_CYCLES), .WIDTH_CYCLES(WIDTH_CYCLES))
    i_fast_gate_checker (.*);
`default_nettype wire

// ===== bench/fast_gate_and_alt_reset_tb.sv
// Self-checking bench of the fast gate and alternate reset block.
`default_nettype none
module fast_gate_and_alt_reset_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DLY = 4;
    localparam int WID = 3;
    logic i_clk = 1'h0, i_reset_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, gq = 1'h0, rq = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rd, o_wb_dat;
    logic o_wb_ack, alt, gate_n, fast_n, shared, kgate, krst_n;
    int n_errors = 0;
    int total_checks = 0;
    always #50 i_clk = ~i_clk;
    fast_gate_and_alt_reset #(.DELAY_CYCLES(DLY), .WIDTH_CYCLES(WID)) i_fast_gate_and_alt_reset (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_kbc_gate_port_bit(kgate),
        .i_kbc_reset_out_n(krst_n), .o_alt_gate_line(alt), .o_gate_output_n(gate_n),
        .o_fast_reset_out_n(fast_n), .o_shared_kbd_reset_pin(shared));
    kbc_side_model i_kbc_side_model (.i_clk(i_clk), .i_gate(gq), .i_reset_req(rq),
        .o_kbc_gate_port_bit(kgate), .o_kbc_reset_out_n(krst_n));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One classic cycle; the request stands until ack is sampled, the watchdog bounds the wait.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, 24'h0, d};
        do @(posedge i_clk); while (o_wb_ack !== 1'h1);
        rd = o_wb_dat;
        {cyc, stb} <= 2'h0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        wb(1'h0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    task automatic settle();
        repeat (8) @(posedge i_clk);
    endtask
    // Counts cycles until the fast reset line drops, giving up after 50.
    task automatic wait_low(output int d);
        d = 0;
        while (fast_n === 1'h1 && d < 50) begin
            @(posedge i_clk);
            d++;
        end
    endtask
    task automatic t_regs();
        settle();
        chk(32'({alt, fast_n, gate_n, shared}), 32'h5);
        rdchk(8'h04, 8'h00);
        wb(1'h1, 8'h00, 8'h03);
        rdchk(8'h00, 8'h00);
        wb(1'h1, 8'h04, 8'h04);
        rdchk(8'h00, 8'h24);
        wb(1'h1, 8'h00, 8'hFE);
        rdchk(8'h00, 8'h26);
        rdchk(8'h08, 8'h00);
    endtask
    task automatic t_gate();
        for (int i = 0; i < 4; i++) begin
            gq <= i[1];
            wb(1'h1, 8'h00, {6'h0, i[0], 1'h0});
            settle();
            chk(32'({alt, gate_n}), 32'({i[0], i[1] | i[0]}));
        end
    endtask
    task automatic t_pulse();
        int d;
        int w;
        wb(1'h1, 8'h00, 8'h01);
        wait_low(d);
        chk(32'(d >= DLY && d < 50), 32'h1);
        for (w = 0; fast_n === 1'h0 && w < 50; w++) begin
            if (w == 1) chk(32'(shared), 32'h0);
            @(posedge i_clk);
        end
        chk(32'(w), 32'(WID));
        rdchk(8'h00, 8'h25);
        wb(1'h1, 8'h00, 8'h01);
        wait_low(d);
        chk(32'(d), 32'd50);
        wb(1'h1, 8'h00, 8'h00);
        wb(1'h1, 8'h00, 8'h01);
        wait_low(d);
        chk(32'(d < 50), 32'h1);
        settle();
    endtask
    task automatic t_pol();
        wb(1'h1, 8'h04, 8'h0C);
        settle();
        chk(32'(shared), 32'h0);
        rq <= 1'h1;
        settle();
        chk(32'(shared), 32'h1);
        wb(1'h1, 8'h04, 8'h00);
        settle();
        chk(32'(shared), 32'h0);
        rq <= 1'h0;
        i_reset_n <= 1'h0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'h1;
        wb(1'h1, 8'h04, 8'h04);
        rdchk(8'h00, 8'h24);
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'h1;
        t_regs();
        t_gate();
        t_pulse();
        t_pol();
        stop_test();
    end
    // Cuts a hang short well after the expected run of a few hundred cycles.
    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
